//--- sbf_regs.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 32-bit register data, byte addresses on an 8-bit address
// Notes:   included by the fault manager and its package users
`ifndef SBF_REGS_SVH
`define SBF_REGS_SVH

// register byte addresses
`define SBF_ADDR_STATUS     8'h00
`define SBF_ADDR_CURRENT    8'h04
`define SBF_ADDR_CONFIG     8'h08
`define SBF_ADDR_STATE      8'h0c

// status flag positions
`define SBF_FLAG_INPUT_OV   0
`define SBF_FLAG_LOGIC_UV   1
`define SBF_FLAG_INPUT_OC   2
`define SBF_FLAG_PUMP       3
`define SBF_FLAG_PUMP_CAP   4
`define SBF_FLAG_CFG_ERR    5
`define SBF_FLAG_BOOST_OVL  6
`define SBF_FLAG_BOOST_OVH  7
`define SBF_FLAG_BOOST_OC   8
`define SBF_FLAG_STRING     9
`define SBF_FLAG_MODE       10
`define SBF_FLAG_FREQ       11
`define SBF_FLAG_CURRENT_SET_PIN       12
`define SBF_FLAG_INPUT_UV   13
`define SBF_FLAG_COUNT      14

// reset values and strap fallbacks
`define SBF_CURRENT_RESET   12'hfff
`define SBF_STRING_DEFAULT  3'h0
`define SBF_MODE_DEFAULT    2'h0
`define SBF_ADDR_DEFAULT    7'h2a
`define SBF_BOOSTF_DEFAULT  3'h2
`define SBF_DIMF_DEFAULT    3'h1

// timing
`define SBF_CLK_PERIOD_NS   10
`define SBF_RECOVERY_MS     100
`define SBF_BOOST_OC_MS     110
`define SBF_RECOVERY_CYCLES (`SBF_RECOVERY_MS * 1000000 / `SBF_CLK_PERIOD_NS)
`define SBF_BOOST_OC_CYCLES (`SBF_BOOST_OC_MS * 1000000 / `SBF_CLK_PERIOD_NS)

`endif

//--- sbf_pkg.sv
// Purpose: types shared by the fault manager and its users
// Assumes: nothing beyond the register header
// Notes:   states are gray coded along init, soft start, run
package sbf_pkg;

  // supervisor states
  typedef enum logic [2:0] {
    SBF_ST_INIT    = 3'h0,
    SBF_ST_SOFT    = 3'h1,
    SBF_ST_RUN     = 3'h3,
    SBF_ST_RECOVER = 3'h2,
    SBF_ST_STANDBY = 3'h6
  } sbf_state_type;

  // comparator outputs arriving from the analog side
  typedef struct packed {
    logic input_ov;    // input voltage sense above overvoltage level
    logic logic_uv;    // logic supply below undervoltage level
    logic input_uv;    // undervoltage pin below its threshold
    logic input_oc;    // input sense resistor drop above limit
    logic pump_low;    // pump output node below minimum
    logic boost_ovl;   // boost feedback above low overvoltage level
    logic boost_ovh;   // feedback or output node a above high level
    logic boost_uv;    // boost feedback below undervoltage level
    logic current_set_pin_short;  // current set pin shorted to ground
  } sbf_sense_type;

  // strap decoder results, same clock
  typedef struct packed {
    logic       string_ok;
    logic [2:0] string_code;
    logic       mode_ok;
    logic [1:0] mode_code;
    logic [6:0] mode_addr;
    logic       boost_f_ok;
    logic [2:0] boost_f_code;
    logic       dim_f_ok;
    logic [2:0] dim_f_code;
  } sbf_strap_type;

  // initialization check results, same clock
  typedef struct packed {
    logic pump_cap_bad;  // flying capacitor open or shorted
    logic config_bad;    // factory configuration failed integrity
  } sbf_init_type;

  // register port request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } sbf_bus_req_type;

endpackage

//--- sbf_fault_manager.sv
// Purpose: supply, boost and strap fault supervisor for a backlight driver
// Assumes: comparators deliver levels; straps decoded on this clock
// Notes:   status flags are write-one-to-clear, set wins over clear
`timescale 1ns/1ps
`default_nettype none
`include "sbf_regs.svh"

module sbf_fault_manager #(
  parameter int REC_CYCLES = `SBF_RECOVERY_CYCLES,  // recovery delay
  parameter int BOC_CYCLES = `SBF_BOOST_OC_CYCLES   // boost oc timer
) (
  // clock and reset
  input  wire logic                    SYS_CLK_I,
  input  wire logic                    RST_I,
  // analog comparators and start-up status
  input  wire sbf_pkg::sbf_sense_type  SENSE_I,
  input  wire sbf_pkg::sbf_strap_type  STRAP_I,
  input  wire sbf_pkg::sbf_init_type   INIT_I,
  input  wire logic                    SOFT_DONE_I,
  input  wire logic                    CYCLE_LIMIT_I,
  // register port
  input  wire sbf_pkg::sbf_bus_req_type BUS_REQ_I,
  output logic [31:0]                  RD_DATA_O,
  // power stage controls and interrupt
  output logic                         BOOST_EN_O,
  output logic                         BOOST_HALT_O,
  output logic                         SINK_EN_O,
  output logic                         FET_EN_O,
  output logic                         PUMP_EN_O,
  output logic                         INT_O,
  // latched configuration
  output logic [11:0]                  CUR_CODE_O,
  output logic [2:0]                   STRING_CFG_O,
  output logic [1:0]                   DIM_MODE_O,
  output logic [6:0]                   BUS_ADDR_O,
  output logic [2:0]                   BOOST_FREQ_O,
  output logic [2:0]                   DIM_FREQ_O
);
  import sbf_pkg::*;

  localparam int NF  = `SBF_FLAG_COUNT;
  localparam int RCW = $clog2(REC_CYCLES + 1);
  localparam int BCW = $clog2(BOC_CYCLES + 1);

  // pick a strap code or its fallback
  function automatic logic [2:0] pick3(input logic ok,
                                       input logic [2:0] code,
                                       input logic [2:0] dflt);
    pick3 = ok ? code : dflt;
  endfunction

  sbf_sense_type     sns1_ff;       // first stage, read by second only
  sbf_sense_type     sns2_ff;       // second stage
  sbf_sense_type     sns3_ff;       // third stage
  sbf_sense_type     sns_ff;        // accepted comparator levels
  sbf_state_type     state_ff;      // supervisor state
  sbf_state_type     nxt_state;     // next supervisor state
  logic [NF-1:0]     flags_ff;      // sticky status flags
  logic [NF-1:0]     nxt_set;       // flag set events this cycle
  logic [NF-1:0]     clr_w1c;       // host clear mask
  logic [11:0]       prog_ff;       // programmed current code
  logic              cfg_done_ff;   // straps already sampled
  logic [RCW-1:0]    rec_cnt_ff;    // recovery delay counter
  logic [BCW-1:0]    boc_cnt_ff;    // boost undervoltage timer
  logic              running;       // boost soft start or run
  logic              standby_cause; // any supply fault that parks
  logic              rec_cause;     // any running fault that recovers
  logic              boc_hit;       // boost oc timer expires now
  logic              rec_end;       // recovery delay done
  logic              strap_take;    // sample straps this cycle

  // three stage sync; accept once stages two and three agree
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      sns1_ff <= '0;
      sns2_ff <= '0;
      sns3_ff <= '0;
      sns_ff  <= '0;
    end else begin
      sns1_ff <= SENSE_I;
      sns2_ff <= sns1_ff;
      sns3_ff <= sns2_ff;
      if (sns2_ff == sns3_ff) begin
        sns_ff <= sns3_ff;
      end
    end
  end

  // fault classification
  always_comb begin
    running       = (state_ff == SBF_ST_SOFT) || (state_ff == SBF_ST_RUN);
    standby_cause = sns_ff.input_ov | sns_ff.logic_uv
                  | sns_ff.input_uv;
    boc_hit       = running && sns_ff.boost_uv
                  && (boc_cnt_ff == BCW'(BOC_CYCLES - 1));
    rec_cause     = running && (sns_ff.input_oc
                  || sns_ff.pump_low
                  || sns_ff.boost_ovh)
                  || boc_hit;
    rec_end       = (rec_cnt_ff == RCW'(REC_CYCLES - 1));
    strap_take    = (state_ff == SBF_ST_INIT) && !cfg_done_ff;
  end

  // next state; every restart passes through init again
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SBF_ST_INIT: begin
        if (standby_cause) begin
          nxt_state = SBF_ST_STANDBY;
        end else if (INIT_I.pump_cap_bad) begin
          nxt_state = SBF_ST_RECOVER;
        end else begin
          nxt_state = SBF_ST_SOFT;     // config error keeps going
        end
      end
      SBF_ST_SOFT, SBF_ST_RUN: begin
        if (standby_cause) begin
          nxt_state = SBF_ST_STANDBY;
        end else if (rec_cause) begin
          nxt_state = SBF_ST_RECOVER;
        end else if (SOFT_DONE_I) begin
          nxt_state = SBF_ST_RUN;
        end
      end
      SBF_ST_RECOVER: begin
        if (standby_cause) begin
          nxt_state = SBF_ST_STANDBY;
        end else if (rec_end) begin
          nxt_state = SBF_ST_INIT;
        end
      end
      SBF_ST_STANDBY: begin
        if (!standby_cause) begin
          nxt_state = SBF_ST_INIT;
        end
      end
      default: nxt_state = SBF_ST_INIT;
    endcase
  end

  // state register and power stage enables, aligned to the state
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      state_ff   <= SBF_ST_INIT;
      BOOST_EN_O <= 1'b0;
      SINK_EN_O  <= 1'b0;
      FET_EN_O   <= 1'b0;
      PUMP_EN_O  <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      BOOST_EN_O <= (nxt_state == SBF_ST_SOFT) || (nxt_state == SBF_ST_RUN);
      SINK_EN_O  <= (nxt_state == SBF_ST_SOFT) || (nxt_state == SBF_ST_RUN);
      FET_EN_O   <= (nxt_state == SBF_ST_SOFT) || (nxt_state == SBF_ST_RUN);
      // pump stays off while parked or recovering
      PUMP_EN_O  <= (nxt_state != SBF_ST_RECOVER)
                 && (nxt_state != SBF_ST_STANDBY);
    end
  end

  // switching halt: low overvoltage and the cycle limit only
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      BOOST_HALT_O <= 1'b0;
    end else begin
      BOOST_HALT_O <= (running && sns_ff.boost_ovl)
                   || CYCLE_LIMIT_I;
    end
  end

  // recovery delay counter, restarts on each entry
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      rec_cnt_ff <= '0;
    end else if (state_ff == SBF_ST_RECOVER && !rec_end) begin
      rec_cnt_ff <= rec_cnt_ff + RCW'(1);
    end else begin
      rec_cnt_ff <= '0;
    end
  end

  // boost undervoltage timer, runs while boost runs with feedback low
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      boc_cnt_ff <= '0;
    end else if (running && sns_ff.boost_uv && !boc_hit) begin
      boc_cnt_ff <= boc_cnt_ff + BCW'(1);
    end else begin
      boc_cnt_ff <= '0;
    end
  end

  // straps sampled once after reset and then held
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      cfg_done_ff  <= 1'b0;
      STRING_CFG_O <= `SBF_STRING_DEFAULT;
      DIM_MODE_O   <= `SBF_MODE_DEFAULT;
      BUS_ADDR_O   <= `SBF_ADDR_DEFAULT;
      BOOST_FREQ_O <= `SBF_BOOSTF_DEFAULT;
      DIM_FREQ_O   <= `SBF_DIMF_DEFAULT;
    end else if (strap_take) begin
      cfg_done_ff  <= 1'b1;
      STRING_CFG_O <= pick3(STRAP_I.string_ok, STRAP_I.string_code,
                            `SBF_STRING_DEFAULT);
      DIM_MODE_O   <= STRAP_I.mode_ok ? STRAP_I.mode_code
                                      : `SBF_MODE_DEFAULT;
      BUS_ADDR_O   <= STRAP_I.mode_ok ? STRAP_I.mode_addr
                                      : `SBF_ADDR_DEFAULT;
      BOOST_FREQ_O <= pick3(STRAP_I.boost_f_ok, STRAP_I.boost_f_code,
                            `SBF_BOOSTF_DEFAULT);
      DIM_FREQ_O   <= pick3(STRAP_I.dim_f_ok, STRAP_I.dim_f_code,
                            `SBF_DIMF_DEFAULT);
    end
  end

  // flag set events; a persisting fault sets again each cycle
  always_comb begin
    nxt_set = '0;
    nxt_set[`SBF_FLAG_INPUT_OV]  = sns_ff.input_ov;
    nxt_set[`SBF_FLAG_LOGIC_UV]  = sns_ff.logic_uv;
    nxt_set[`SBF_FLAG_INPUT_UV]  = sns_ff.input_uv;
    nxt_set[`SBF_FLAG_INPUT_OC]  = running && sns_ff.input_oc;
    nxt_set[`SBF_FLAG_PUMP]      = (running && sns_ff.pump_low)
      || (state_ff == SBF_ST_INIT && INIT_I.pump_cap_bad);
    nxt_set[`SBF_FLAG_PUMP_CAP]  = (state_ff == SBF_ST_INIT)
      && INIT_I.pump_cap_bad;
    nxt_set[`SBF_FLAG_CFG_ERR]   = (state_ff == SBF_ST_INIT)
      && INIT_I.config_bad;
    nxt_set[`SBF_FLAG_BOOST_OVL] = running && sns_ff.boost_ovl;
    nxt_set[`SBF_FLAG_BOOST_OVH] = running && sns_ff.boost_ovh;
    nxt_set[`SBF_FLAG_BOOST_OC]  = boc_hit;
    nxt_set[`SBF_FLAG_STRING]    = strap_take && !STRAP_I.string_ok;
    nxt_set[`SBF_FLAG_MODE]      = strap_take && !STRAP_I.mode_ok;
    nxt_set[`SBF_FLAG_FREQ]      = strap_take
      && !(STRAP_I.boost_f_ok && STRAP_I.dim_f_ok);
    nxt_set[`SBF_FLAG_CURRENT_SET_PIN]      = sns_ff.current_set_pin_short;
    clr_w1c = (BUS_REQ_I.wr && BUS_REQ_I.addr == `SBF_ADDR_STATUS)
            ? BUS_REQ_I.wdata[NF-1:0] : '0;
  end

  // sticky flags and interrupt; set wins over host clear
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      flags_ff <= '0;
      INT_O    <= 1'b0;
    end else begin
      flags_ff <= (flags_ff & ~clr_w1c) | nxt_set;
      INT_O    <= |((flags_ff & ~clr_w1c) | nxt_set);
    end
  end

  // programmed current code and effective code to the sinks
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      prog_ff    <= `SBF_CURRENT_RESET;
      CUR_CODE_O <= `SBF_CURRENT_RESET;
    end else begin
      if (BUS_REQ_I.wr && BUS_REQ_I.addr == `SBF_ADDR_CURRENT) begin
        prog_ff <= BUS_REQ_I.wdata[11:0];
      end
      // sink current scales as code over full scale 4095
      CUR_CODE_O <= sns_ff.current_set_pin_short ? {2'h0, prog_ff[11:2]}
                                      : prog_ff;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      RD_DATA_O <= '0;
    end else if (BUS_REQ_I.rd) begin
      case (BUS_REQ_I.addr)
        `SBF_ADDR_STATUS:  RD_DATA_O <= {{(32-NF){1'b0}}, flags_ff};
        `SBF_ADDR_CURRENT: RD_DATA_O <= {20'h0, prog_ff};
        `SBF_ADDR_CONFIG:  RD_DATA_O <= {14'h0, DIM_FREQ_O, BOOST_FREQ_O,
                                         BUS_ADDR_O, DIM_MODE_O,
                                         STRING_CFG_O};
        `SBF_ADDR_STATE:   RD_DATA_O <= {29'h0, state_ff};
        default:           RD_DATA_O <= '0;  // unmapped reads zero
      endcase
    end else begin
      RD_DATA_O <= '0;
    end
  end

  // checks
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);

  chk_ov_standby: assert property (
    sns_ff.input_ov |=> state_ff == SBF_ST_STANDBY && !BOOST_EN_O
      && !SINK_EN_O && !FET_EN_O && flags_ff[`SBF_FLAG_INPUT_OV] && INT_O)
    else $error("overvoltage did not park the device");
  chk_uv_standby: assert property (
    sns_ff.logic_uv |=> state_ff == SBF_ST_STANDBY && !FET_EN_O
      && flags_ff[`SBF_FLAG_LOGIC_UV])
    else $error("logic undervoltage did not park the device");
  chk_standby_exit: assert property (
    state_ff == SBF_ST_STANDBY && !standby_cause |=> state_ff == SBF_ST_INIT
      ##1 state_ff != SBF_ST_STANDBY || standby_cause)
    else $error("standby not left after supply recovered");
  chk_oc_recover: assert property (
    running && sns_ff.input_oc && !standby_cause |=>
      state_ff == SBF_ST_RECOVER && !BOOST_EN_O && !PUMP_EN_O
      && flags_ff[`SBF_FLAG_INPUT_OC])
    else $error("input overcurrent did not start recovery");
  chk_rec_delay: assert property (
    $rose(state_ff == SBF_ST_RECOVER) && !standby_cause |->
      rec_cnt_ff == '0 ##1 rec_cnt_ff == RCW'(1))
    else $error("recovery delay did not start from zero");
  chk_rec_end: assert property (
    state_ff == SBF_ST_RECOVER && rec_end && !standby_cause
      |=> state_ff == SBF_ST_INIT)
    else $error("recovery did not restart at the delay end");
  chk_ovl_halt: assert property (
    running && sns_ff.boost_ovl && !standby_cause && !rec_cause
      |=> BOOST_HALT_O && state_ff != SBF_ST_RECOVER
      && flags_ff[`SBF_FLAG_BOOST_OVL])
    else $error("low overvoltage did not halt switching");
  // a quiet run with the limit active must stay in run with no new flag
  chk_cycle_limit: assert property (
    CYCLE_LIMIT_I && state_ff == SBF_ST_RUN && sns_ff == '0
      |=> BOOST_HALT_O && state_ff == SBF_ST_RUN
      && (flags_ff & ~$past(flags_ff)) == '0)
    else $error("cycle limit raised a fault");
  chk_current_set_pin_quarter: assert property (
    sns_ff.current_set_pin_short |=> CUR_CODE_O == ($past(prog_ff) >> 2)
      && flags_ff[`SBF_FLAG_CURRENT_SET_PIN])
    else $error("current code not reduced to a quarter");
  chk_straps_hold: assert property (
    cfg_done_ff |=> $stable(STRING_CFG_O) && $stable(DIM_MODE_O)
      && $stable(BUS_ADDR_O) && $stable(BOOST_FREQ_O)
      && $stable(DIM_FREQ_O))
    else $error("strap configuration changed after init");
  chk_set_wins: assert property (
    nxt_set[`SBF_FLAG_CURRENT_SET_PIN] && clr_w1c[`SBF_FLAG_CURRENT_SET_PIN]
      |=> flags_ff[`SBF_FLAG_CURRENT_SET_PIN] && INT_O)
    else $error("clear overrode a new fault event");
  chk_boc_fire: assert property (
    boc_hit && !standby_cause |=> state_ff == SBF_ST_RECOVER
      && flags_ff[`SBF_FLAG_BOOST_OC])
    else $error("boost overcurrent timer did not fault");

  cov_ov_cycle:  cover property (
    sns_ff.input_ov ##1 state_ff == SBF_ST_STANDBY ##[1:50]
    state_ff == SBF_ST_INIT);
  cov_recovery:  cover property (
    state_ff == SBF_ST_RECOVER ##1 state_ff == SBF_ST_RECOVER);
  cov_current_set_pin:      cover property (
    sns_ff.current_set_pin_short ##1 !sns_ff.current_set_pin_short);
  cov_strap_bad: cover property (strap_take && !STRAP_I.mode_ok);

endmodule // sbf_fault_manager

`default_nettype wire

//--- sbf_analog_model.sv
// Purpose: analog side model: comparator levels and soft start finish
// Assumes: comparator levels follow the bench command
// Notes:   soft start ends a fixed count after the boost enable rises
`timescale 1ns/1ps
`default_nettype none

module sbf_analog_model (
  // clock and reset
  input  wire logic           clk_i,
  input  wire logic           rst_i,
  // boost enable from the supervisor, comparator command
  input  wire logic           boost_en_i,
  input  wire sbf_pkg::sbf_sense_type sense_cmd_i,
  // comparator levels and soft start done
  output sbf_pkg::sbf_sense_type sense_o,
  output logic                soft_done_o
);
  import sbf_pkg::*;

  logic [2:0] soft_cnt_ff;  // cycles the boost has run

  // comparators are levels with no clock relation
  assign sense_o = sense_cmd_i;

  // soft start restarts whenever the boost is stopped
  always_ff @(posedge clk_i) begin
    if (rst_i || !boost_en_i) begin
      soft_cnt_ff <= 3'h0;
    end else if (soft_cnt_ff != 3'h5) begin
      soft_cnt_ff <= soft_cnt_ff + 3'h1;
    end
  end

  // output is reached only after the ramp
  assign soft_done_o = (soft_cnt_ff == 3'h5);
endmodule  // sbf_analog_model
`default_nettype wire

//--- tb_sbf_fault_manager.sv
// Purpose: self-checking bench for the fault supervisor
// Assumes: recovery delay 20 and boost timer 30 cycles in simulation
// Notes:   straps read invalid at the first initialization
`timescale 1ns/1ps
`default_nettype none
`include "sbf_regs.svh"

module tb_sbf_fault_manager;
  import sbf_pkg::*;

  logic            clk, rst, soft_done, cyc_lim, boost_en, halt;
  logic            sink_en, fet_en, pump_en, irq;
  sbf_sense_type   sense, cmd;
  sbf_strap_type   strap;
  sbf_init_type    init;
  sbf_bus_req_type req;
  logic [31:0]     rdata;
  logic [11:0]     cur;
  logic [2:0]      str_cfg, bfreq, dfreq;
  logic [1:0]      dmode;
  logic [6:0]      baddr;
  int              num_errors, n_compared, cycles;
  // fault table: sense bit, flag bit, state entered
  int              pos[6] = '{8, 7, 6, 5, 4, 2};
  int              flg[6] = '{0, 1, 13, 2, 3, 7};
  int              sts[6] = '{6, 6, 6, 2, 2, 2};

  sbf_fault_manager #(.REC_CYCLES(20), .BOC_CYCLES(30)) uut (
    .SYS_CLK_I(clk), .RST_I(rst), .SENSE_I(sense), .STRAP_I(strap),
    .INIT_I(init), .SOFT_DONE_I(soft_done), .CYCLE_LIMIT_I(cyc_lim),
    .BUS_REQ_I(req), .RD_DATA_O(rdata), .BOOST_EN_O(boost_en),
    .BOOST_HALT_O(halt), .SINK_EN_O(sink_en), .FET_EN_O(fet_en),
    .PUMP_EN_O(pump_en), .INT_O(irq), .CUR_CODE_O(cur),
    .STRING_CFG_O(str_cfg), .DIM_MODE_O(dmode), .BUS_ADDR_O(baddr),
    .BOOST_FREQ_O(bfreq), .DIM_FREQ_O(dfreq));

  sbf_analog_model pm (
    .clk_i(clk), .rst_i(rst), .boost_en_i(boost_en),
    .sense_cmd_i(cmd), .sense_o(sense), .soft_done_o(soft_done));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      num_errors++;
      results();
    end
  end

  task automatic results();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req.wr    <= 1'b1;
    req.addr  <= a;
    req.wdata <= d;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  // read data stands in the cycle after the strobe only; it is
  // sampled at the edge that closes that cycle, so the task ends on
  // an edge and later stimulus still changes right at an edge
  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic [31:0] m);
    @(posedge clk);
    req.rd   <= 1'b1;
    req.addr <= a;
    @(posedge clk);
    req.rd <= 1'b0;
    @(posedge clk);
    chk(rdata & m, exp);
  endtask

  task automatic st(input logic [31:0] s);
    rd(`SBF_ADDR_STATE, s, 32'h7);
  endtask

  task automatic clr();
    wr(`SBF_ADDR_STATUS, 32'hffffffff);
    rd(`SBF_ADDR_STATUS, 32'h0, 32'hffffffff);
  endtask

  task automatic chk_straps();
    chk({str_cfg, dmode, baddr, bfreq, dfreq},
        {`SBF_STRING_DEFAULT, `SBF_MODE_DEFAULT, `SBF_ADDR_DEFAULT,
         `SBF_BOOSTF_DEFAULT, `SBF_DIMF_DEFAULT});
  endtask

  initial begin
    rst = 1'b1;
    cmd = '0;
    cyc_lim = 1'b0;
    req = '0;
    strap = '0;
    init = 2'b01;
    num_errors = 0;
    n_compared = 0;
    cycles = 0;
    wait_cyc(12);
    rst <= 1'b0;
    // straps are sampled at this edge only; init checks at every pass through init
    @(posedge clk);
    strap <= '1;
    init <= '0;
    chk(cur, 12'hfff);
    wait_cyc(20);
    chk_straps();
    rd(`SBF_ADDR_STATUS, 32'h0e20, 32'hffffffff);
    chk(irq, 1'b1);
    st(3'h3);
    rd(`SBF_ADDR_CURRENT, 32'hfff, 32'hffffffff);
    clr();
    chk(irq, 1'b0);
    // supply and boost faults, each followed by a restart
    for (int i = 0; i < 6; i++) begin
      cmd <= sbf_sense_type'(9'h1 << pos[i]);
      wait_cyc(8);
      st(sts[i]);
      chk({boost_en, sink_en, fet_en, pump_en}, 4'h0);
      rd(`SBF_ADDR_STATUS, 32'h1 << flg[i], 32'h1 << flg[i]);
      chk(irq, 1'b1);
      cmd <= '0;
      wait_cyc(45);
      st(3'h3);
      chk({boost_en, sink_en, fet_en, pump_en}, 4'hf);
      clr();
    end
    // bad pump capacitor seen at the restart
    cmd.input_oc <= 1'b1;
    init.pump_cap_bad <= 1'b1;
    wait_cyc(8);
    cmd <= '0;
    wait_cyc(25);
    st(3'h2);
    rd(`SBF_ADDR_STATUS, 32'h18, 32'h18);
    chk(pump_en, 1'b0);
    init <= '0;
    wait_cyc(45);
    st(3'h3);
    clr();
    // low boost overvoltage only halts switching
    cmd.boost_ovl <= 1'b1;
    wait_cyc(8);
    chk(halt, 1'b1);
    st(3'h3);
    rd(`SBF_ADDR_STATUS, 32'h40, 32'h40);
    cmd <= '0;
    wait_cyc(8);
    chk(halt, 1'b0);
    clr();
    // cycle limit raises no fault
    cyc_lim <= 1'b1;
    wait_cyc(3);
    chk(halt, 1'b1);
    rd(`SBF_ADDR_STATUS, 32'h0, 32'hffffffff);
    st(3'h3);
    cyc_lim <= 1'b0;
    // feedback held low past the boost timer
    cmd.boost_uv <= 1'b1;
    wait_cyc(40);
    st(3'h2);
    rd(`SBF_ADDR_STATUS, 32'h100, 32'h100);
    cmd <= '0;
    wait_cyc(45);
    clr();
    // current set short quarters the code, then restores it
    wr(`SBF_ADDR_CURRENT, 32'h800);
    cmd.current_set_pin_short <= 1'b1;
    wait_cyc(8);
    chk(cur, 12'h200);
    rd(`SBF_ADDR_STATUS, 32'h1000, 32'h1000);
    // clear while the short persists: the new event must win
    wr(`SBF_ADDR_STATUS, 32'h1000);
    rd(`SBF_ADDR_STATUS, 32'h1000, 32'h1000);
    chk(irq, 1'b1);
    cmd <= '0;
    wait_cyc(8);
    chk(cur, 12'h800);
    rd(`SBF_ADDR_CURRENT, 32'h800, 32'hffffffff);
    // straps kept across restarts, unmapped read is zero
    chk_straps();
    rd(8'h10, 32'h0, 32'hffffffff);
    // mid-run reset: straps now read valid and are taken as coded
    rst <= 1'b1;
    wait_cyc(4);
    rst <= 1'b0;
    chk(irq, 1'b0);
    wait_cyc(20);
    chk({str_cfg, dmode, baddr, bfreq, dfreq}, 18'h3ffff);
    rd(`SBF_ADDR_STATUS, 32'h0, 32'hffffffff);
    st(3'h3);
    results();
  end
endmodule  // tb_sbf_fault_manager
`default_nettype wire
